// ===== cfg_loader_pkg.sv
// constants, register map and state codes of the configuration loader
// assumes a 100 MHz system clock and a 32-bit classic wishbone register bus

package cfg_loader_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_DATA = 8'h08;
  localparam logic [7:0] REG_GPIO_OE = 8'h0c;
  localparam logic [7:0] REG_GPIO_OUT = 8'h10;
  localparam logic [7:0] REG_GPIO_IN = 8'h14;
  localparam logic [7:0] REG_STRAPS = 8'h18;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_ADDR_LSB = 0;
  localparam int CTRL_COUNT_LSB = 8;
  localparam int CTRL_START_BIT = 31;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_LOAD_EN_BIT = 1;
  localparam int ST_AVAIL_BIT = 2;
  localparam int ST_FULL_BIT = 3;
  localparam int ST_REFUSED_BIT = 4;
  localparam int ST_STRAPS_BIT = 5;
  localparam int DATA_VALID_BIT = 31;
  localparam int SP_ADDR_LSB = 0;
  localparam int SP_I2C_BIT = 7;
  localparam int SP_DEBUG_BIT = 8;
  localparam int SP_LANE_LSB = 9;
  localparam int SP_DBGSEL_LSB = 11;
  localparam int SP_LOAD_EN_BIT = 16;

  // ----------------------------------------------------------------
  // reset values and fixed codes
  // ----------------------------------------------------------------
  localparam logic [7:0] GPIO_OE_RESET = 8'h00;
  localparam logic [7:0] GPIO_OUT_RESET = 8'h00;
  // upper slave address bits, value arbitrary
  localparam logic [3:0] SLAVE_ADDR_UPPER = 4'h0;
  localparam logic [1:0] LANE_5P5L = 2'h0;
  localparam logic [1:0] LANE_6P6L = 2'h1;
  localparam logic [1:0] LANE_5P6L = 2'h2;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int SYS_CLK_PERIOD_NS = 10;
  localparam int ROM_CLK_PERIOD_NS = 80;
  localparam int ROM_HALF_CYCLES = ROM_CLK_PERIOD_NS / (2 * SYS_CLK_PERIOD_NS);
  localparam logic [2:0] ROM_HALF_LOAD = 3'(ROM_HALF_CYCLES - 1);
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  // ----------------------------------------------------------------
  // serial rom frame
  // ----------------------------------------------------------------
  localparam int ROM_ADDR_BITS = 6;
  localparam int ROM_DATA_BITS = 16;
  localparam logic [2:0] ROM_READ_OPCODE = 3'h6;
  localparam int ROM_CMD_BITS = 3 + ROM_ADDR_BITS;
  localparam int ROM_RESP_BITS = ROM_DATA_BITS + 1;
  localparam logic [4:0] ROM_CMD_LAST = 5'(ROM_CMD_BITS - 1);
  localparam logic [4:0] ROM_FRAME_LAST = 5'(ROM_CMD_BITS + ROM_RESP_BITS - 1);
  localparam int FIFO_DEPTH = 16;

  typedef enum logic [2:0]
  {
    ROM_IDLE = 3'b000,
    ROM_SETUP = 3'b001,
    ROM_SHIFT = 3'b010,
    ROM_PUSH = 3'b011,
    ROM_GAP = 3'b100
  } rom_state_t;

endpackage : cfg_loader_pkg

// ===== word_fifo.sv
// word fifo with a registered output stage
// assumes one clock and a synchronous active-high reset

`timescale 1ns/10ps

module word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // filling side
  input wire logic wr_valid_i,
  input wire logic [WIDTH-1:0] wr_data_i,
  output logic wr_ready_o,
  // draining side
  output logic rd_valid_o,
  output logic [WIDTH-1:0] rd_data_o,
  input wire logic rd_ready_i
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0] count;
    logic out_valid;
    logic [WIDTH-1:0] out_data;
  } fifo_state_t;

  fifo_state_t r;
  fifo_state_t next_r;
  logic push;
  logic load;

  always_comb
  begin
    next_r = r;
    push = wr_valid_i && (r.count != DEPTH_C);
    load = (r.count != '0) && (!r.out_valid || rd_ready_i);
    if (rd_ready_i)
    begin
      next_r.out_valid = 1'b0;
    end
    if (push)
    begin
      next_r.mem[r.wptr] = wr_data_i;
      next_r.wptr = r.wptr + 1'b1;
    end
    if (load)
    begin
      next_r.out_data = r.mem[r.rptr];
      next_r.out_valid = 1'b1;
      next_r.rptr = r.rptr + 1'b1;
    end
    next_r.count = r.count + (AW+1)'(push) - (AW+1)'(load);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      r <= '0;
    end
    else
    begin
      r <= next_r;
    end
  end

  assign wr_ready_o = (r.count != DEPTH_C);
  assign rd_valid_o = r.out_valid;
  assign rd_data_o = r.out_data;

endmodule : word_fifo

// ===== cfg_loader.sv
// configuration loader: serial rom reader, strap capture and general-purpose pins
// assumes pins are asynchronous to clk_i; board straps are stable around reset release
//
// The register offsets and the Wishbone slave port were decided locally.

`timescale 1ns/10ps

module cfg_loader
  import cfg_loader_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // serial rom port
  output logic rom_serial_clock_o,
  output logic rom_serial_out_o,
  input wire logic rom_serial_in_i,
  input wire logic rom_select_n_i,
  output logic rom_select_n_o,
  output logic rom_select_n_oe_o,
  // strap pins
  input wire logic debug_off_strap_i,
  input wire logic protocol_strap_i,
  input wire logic [2:0] slave_addr_strap_i,
  // general-purpose pins
  input wire logic [7:0] gpio_i,
  output logic [7:0] gpio_o,
  output logic [7:0] gpio_oe_o,
  // latched configuration
  output logic [6:0] slave_addr_o,
  output logic i2c_mode_o,
  output logic debug_mode_o,
  output logic [1:0] lane_config_o,
  output logic [4:0] debug_select_o,
  output logic rom_load_en_o,
  output logic straps_valid_o
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
    logic [7:0] gpio_oe;
    logic [7:0] gpio_out;
    logic refused;
    logic [7:0] gpio_s1, gpio_s2;
    logic sel_s1, sel_s2;
    logic dbg_s1, dbg_s2;
    logic prot_s1, prot_s2;
    logic [2:0] addr_s1, addr_s2;
    logic din_s1, din_s2;
    logic [1:0] settle;
    logic straps_done;
    logic [6:0] slave_addr;
    logic i2c_mode;
    logic debug_mode;
    logic [1:0] lane;
    logic [4:0] dbg_sel;
    logic load_en;
    rom_state_t state;
    logic [2:0] div;
    logic [4:0] bit_cnt;
    logic [ROM_CMD_BITS-1:0] cmd_shift;
    logic [ROM_DATA_BITS-1:0] in_shift;
    logic [ROM_ADDR_BITS-1:0] word_addr;
    logic [3:0] words_left;
    logic sclk;
    logic cs_n;
    logic sdo;
    logic wr_valid;
    logic [ROM_DATA_BITS-1:0] wr_data;
  } loader_state_t;

  loader_state_t r;
  loader_state_t next_r;

  logic fifo_wr_ready;
  logic fifo_rd_valid;
  logic [ROM_DATA_BITS-1:0] fifo_rd_data;
  logic fifo_rd_ready;
  logic take;
  logic [31:0] rd_word;
  logic [1:0] lane_raw;

  // ----------------------------------------------------------------
  // read data fifo
  // ----------------------------------------------------------------
  word_fifo #(
    .WIDTH(ROM_DATA_BITS),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_valid_i(r.wr_valid),
    .wr_data_i(r.wr_data),
    .wr_ready_o(fifo_wr_ready),
    .rd_valid_o(fifo_rd_valid),
    .rd_data_o(fifo_rd_data),
    .rd_ready_i(fifo_rd_ready)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_r = r;
    fifo_rd_ready = 1'b0;
    rd_word = 32'h0000_0000;
    lane_raw = r.gpio_s2[1:0];

    // two-flop synchronisers for every pin
    {next_r.gpio_s1, next_r.sel_s1, next_r.dbg_s1, next_r.prot_s1, next_r.addr_s1, next_r.din_s1} =
      {gpio_i, rom_select_n_i, debug_off_strap_i, protocol_strap_i, slave_addr_strap_i, rom_serial_in_i};
    {next_r.gpio_s2, next_r.sel_s2, next_r.dbg_s2, next_r.prot_s2, next_r.addr_s2, next_r.din_s2} =
      {r.gpio_s1, r.sel_s1, r.dbg_s1, r.prot_s1, r.addr_s1, r.din_s1};

    // strap capture once the synchronisers hold pin levels
    if (!r.straps_done)
    begin
      if (r.settle == STRAP_SETTLE)
      begin
        next_r.straps_done = 1'b1;
        next_r.load_en = r.sel_s2;
        next_r.slave_addr = {SLAVE_ADDR_UPPER, r.addr_s2};
        next_r.debug_mode = !r.dbg_s2;
        next_r.i2c_mode = r.prot_s2;
        next_r.lane = (lane_raw == 2'h3) ? LANE_6P6L : lane_raw;
        next_r.dbg_sel = r.dbg_s2 ? 5'h00 : r.gpio_s2[4:0];
      end
      else
      begin
        next_r.settle = r.settle + 2'h1;
      end
    end

    // wishbone: one wait state, ack for one cycle
    next_r.ack = 1'b0;
    take = wb_cyc_i && wb_stb_i && !r.ack;
    if (take)
    begin
      next_r.ack = 1'b1;
      case (wb_adr_i)
        REG_CTRL:
        begin
          rd_word[CTRL_ADDR_LSB +: ROM_ADDR_BITS] = r.word_addr;
          rd_word[CTRL_COUNT_LSB +: 4] = r.words_left;
        end
        REG_STATUS:
        begin
          rd_word[ST_BUSY_BIT] = (r.state != ROM_IDLE);
          rd_word[ST_LOAD_EN_BIT] = r.load_en;
          rd_word[ST_AVAIL_BIT] = fifo_rd_valid;
          rd_word[ST_FULL_BIT] = !fifo_wr_ready;
          rd_word[ST_REFUSED_BIT] = r.refused;
          rd_word[ST_STRAPS_BIT] = r.straps_done;
        end
        REG_DATA:
        begin
          rd_word[DATA_VALID_BIT] = fifo_rd_valid;
          rd_word[ROM_DATA_BITS-1:0] = fifo_rd_data;
          fifo_rd_ready = !wb_we_i;
        end
        REG_GPIO_OE: rd_word[7:0] = r.gpio_oe;
        REG_GPIO_OUT: rd_word[7:0] = r.gpio_out;
        REG_GPIO_IN: rd_word[7:0] = r.gpio_s2;
        REG_STRAPS:
        begin
          rd_word[SP_ADDR_LSB +: 7] = r.slave_addr;
          rd_word[SP_I2C_BIT] = r.i2c_mode;
          rd_word[SP_DEBUG_BIT] = r.debug_mode;
          rd_word[SP_LANE_LSB +: 2] = r.lane;
          rd_word[SP_DBGSEL_LSB +: 5] = r.dbg_sel;
          rd_word[SP_LOAD_EN_BIT] = r.load_en;
        end
        default: rd_word = 32'h0000_0000;
      endcase
      next_r.dat = wb_we_i ? 32'h0000_0000 : rd_word;
      if (wb_we_i)
      begin
        case (wb_adr_i)
          REG_GPIO_OE:
            if (wb_sel_i[0])
              next_r.gpio_oe = wb_dat_i[7:0];
          REG_GPIO_OUT:
            if (wb_sel_i[0])
              next_r.gpio_out = wb_dat_i[7:0];
          REG_STATUS:
            if (wb_sel_i[0] && wb_dat_i[ST_REFUSED_BIT])
              next_r.refused = 1'b0;
          REG_CTRL:
          begin
            if (wb_sel_i[3] && wb_dat_i[CTRL_START_BIT])
            begin
              if ((r.state != ROM_IDLE) || !r.load_en || !r.straps_done)
              begin
                next_r.refused = 1'b1;
              end
              else
              begin
                next_r.word_addr = wb_dat_i[CTRL_ADDR_LSB +: ROM_ADDR_BITS];
                next_r.words_left = wb_dat_i[CTRL_COUNT_LSB +: 4];
                next_r.state = ROM_SETUP;
                next_r.div = ROM_HALF_LOAD;
              end
            end
          end
          default: next_r.dat = 32'h0000_0000;
        endcase
      end
    end

    // ----------------------------------------------------------------
    // serial rom engine
    // ----------------------------------------------------------------
    case (r.state)
      ROM_IDLE:
      begin
        next_r.cs_n = 1'b1;
        next_r.sclk = 1'b0;
        next_r.sdo = 1'b0;
      end
      ROM_SETUP:
      begin
        // select falls, first bit set up half a clock ahead
        next_r.cs_n = 1'b0;
        next_r.sclk = 1'b0;
        next_r.bit_cnt = 5'h00;
        next_r.cmd_shift = {ROM_READ_OPCODE, r.word_addr};
        next_r.sdo = ROM_READ_OPCODE[2];
        next_r.div = ROM_HALF_LOAD;
        next_r.state = ROM_SHIFT;
      end
      ROM_SHIFT:
      begin
        if (r.div != 3'h0)
        begin
          next_r.div = r.div - 3'h1;
        end
        else
        begin
          next_r.div = ROM_HALF_LOAD;
          next_r.sclk = !r.sclk;
          if (r.sclk)
          begin
            // falling edge: sample response, advance the frame
            if (r.bit_cnt > ROM_CMD_LAST)
            begin
              next_r.in_shift = {r.in_shift[ROM_DATA_BITS-2:0], r.din_s2};
            end
            next_r.cmd_shift = {r.cmd_shift[ROM_CMD_BITS-2:0], 1'b0};
            next_r.sdo = (r.bit_cnt < ROM_CMD_LAST) ? r.cmd_shift[ROM_CMD_BITS-2] : 1'b0;
            next_r.bit_cnt = r.bit_cnt + 5'h01;
            if (r.bit_cnt == ROM_FRAME_LAST)
            begin
              next_r.wr_data = {r.in_shift[ROM_DATA_BITS-2:0], r.din_s2};
              next_r.wr_valid = 1'b1;
              next_r.cs_n = 1'b1;
              next_r.state = ROM_PUSH;
            end
          end
        end
      end
      ROM_PUSH:
      begin
        // wait here while the fifo is full
        if (fifo_wr_ready)
        begin
          next_r.wr_valid = 1'b0;
          next_r.div = ROM_HALF_LOAD;
          next_r.state = ROM_GAP;
        end
      end
      ROM_GAP:
      begin
        if (r.div != 3'h0)
        begin
          next_r.div = r.div - 3'h1;
        end
        else if (r.words_left == 4'h0)
        begin
          next_r.state = ROM_IDLE;
        end
        else
        begin
          next_r.words_left = r.words_left - 4'h1;
          next_r.word_addr = r.word_addr + 6'h01;
          next_r.state = ROM_SETUP;
        end
      end
      default:
      begin
        next_r.state = ROM_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      r <= '0;
      r.gpio_oe <= GPIO_OE_RESET;
      r.gpio_out <= GPIO_OUT_RESET;
      r.cs_n <= 1'b1;
      r.state <= ROM_IDLE;
      r.lane <= LANE_6P6L;
      r.slave_addr <= {SLAVE_ADDR_UPPER, 3'h0};
      r.i2c_mode <= 1'b1;
    end
    else
    begin
      r <= next_r;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign wb_dat_o = r.dat;
  assign wb_ack_o = r.ack;
  assign rom_serial_clock_o = r.sclk;
  assign rom_serial_out_o = r.sdo;
  assign rom_select_n_o = r.cs_n;
  // select pin released until the bypass strap has been taken
  assign rom_select_n_oe_o = r.straps_done;
  assign gpio_o = r.gpio_out;
  assign gpio_oe_o = r.gpio_oe;
  assign slave_addr_o = r.slave_addr;
  assign i2c_mode_o = r.i2c_mode;
  assign debug_mode_o = r.debug_mode;
  assign lane_config_o = r.lane;
  assign debug_select_o = r.dbg_sel;
  assign rom_load_en_o = r.load_en;
  assign straps_valid_o = r.straps_done;

endmodule : cfg_loader

// ===== cfg_loader_assertions.sv
// concurrent checks on the configuration loader ports
// assumes binding to cfg_loader, one clock domain, straps stable around reset release

`timescale 1ns/10ps

module cfg_loader_assertions
  import cfg_loader_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // register bus
  input wire logic wb_ack_o,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  // serial rom port
  input wire logic rom_serial_clock_o,
  input wire logic rom_serial_out_o,
  input wire logic rom_select_n_o,
  // straps and pins
  input wire logic debug_off_strap_i,
  input wire logic protocol_strap_i,
  input wire logic [2:0] slave_addr_strap_i,
  input wire logic [7:0] gpio_i,
  input wire logic [7:0] gpio_oe_o,
  // latched configuration
  input wire logic [6:0] slave_addr_o,
  input wire logic i2c_mode_o,
  input wire logic debug_mode_o,
  input wire logic [1:0] lane_config_o,
  input wire logic [4:0] debug_select_o,
  input wire logic rom_load_en_o,
  input wire logic straps_valid_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  logic [1:0] lane_pin;
  logic [4:0] dbg_pin;
  logic [7:0] oe_val;
  assign lane_pin = gpio_i[1:0];
  assign dbg_pin = gpio_i[4:0];
  assign oe_val = wb_dat_i[7:0];

  // ----------------------------------------------------------------
  // sequences
  // ----------------------------------------------------------------
  sequence high_phase_s;
    rom_serial_clock_o [*4] ##1 !rom_serial_clock_o;
  endsequence
  sequence latch_s;
    $rose(straps_valid_o);
  endsequence

  // ----------------------------------------------------------------
  // serial rom port
  // ----------------------------------------------------------------
  clock_high_a: assert property ($rose(rom_serial_clock_o) |-> high_phase_s)
    else $error("serial clock high phase wrong");
  clock_idle_a: assert property (rom_select_n_o |-> !rom_serial_clock_o)
    else $error("serial clock runs while deselected");
  out_stable_a: assert property (rom_serial_clock_o && $past(rom_serial_clock_o) |-> $stable(rom_serial_out_o))
    else $error("serial output moved in high phase");
  select_early_a: assert property (!straps_valid_o |-> rom_select_n_o)
    else $error("select low before straps latched");
  no_load_a: assert property (straps_valid_o && !rom_load_en_o |-> rom_select_n_o)
    else $error("select low with loading disabled");

  // ----------------------------------------------------------------
  // straps and pin enable write
  // ----------------------------------------------------------------
  strap_addr_a: assert property (latch_s |-> slave_addr_o == {SLAVE_ADDR_UPPER, $past(slave_addr_strap_i, 2)})
    else $error("slave address strap wrong");
  strap_mode_a: assert property (latch_s |->
    i2c_mode_o == $past(protocol_strap_i, 2) && debug_mode_o == !$past(debug_off_strap_i, 2))
    else $error("mode strap wrong");
  strap_lane_a: assert property (latch_s |->
    lane_config_o == (($past(lane_pin, 2) == 2'h3) ? LANE_6P6L : $past(lane_pin, 2)))
    else $error("lane strap wrong");
  strap_debug_a: assert property (latch_s |-> debug_select_o == (debug_mode_o ? $past(dbg_pin, 2) : 5'h00))
    else $error("debug select strap wrong");
  strap_hold_a: assert property (straps_valid_o && $past(straps_valid_o) |->
    $stable({slave_addr_o, i2c_mode_o, debug_mode_o, lane_config_o, debug_select_o, rom_load_en_o}))
    else $error("latched straps changed");
  oe_write_a: assert property (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == REG_GPIO_OE
    |=> gpio_oe_o == $past(oe_val))
    else $error("pin enable did not follow write");
endmodule : cfg_loader_assertions

bind cfg_loader cfg_loader_assertions u_chk (.clk_i, .rst_i, .wb_ack_o, .wb_we_i, .wb_adr_i, .wb_sel_i,
  .wb_dat_i, .rom_serial_clock_o, .rom_serial_out_o, .rom_select_n_o, .debug_off_strap_i, .protocol_strap_i,
  .slave_addr_strap_i, .gpio_i, .gpio_oe_o, .slave_addr_o, .i2c_mode_o, .debug_mode_o, .lane_config_o,
  .debug_select_o, .rom_load_en_o, .straps_valid_o);

// ===== rom_model.sv
// serial rom model: 3-bit read opcode, 6-bit address, dummy bit, 16 data bits
// assumes select and clock come from the loader; word = c3a0 plus address

`timescale 1ns/10ps

module rom_model (
  // rom pins
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic di_i,
  output logic do_o = 1'b0
);
  logic [8:0] cmd = 9'h000;
  logic [8:0] last_cmd = 9'h000;
  logic [15:0] word = 16'h0000;
  int cnt = 0;

  always @(negedge cs_n_i) cnt = 0;
  // released line shows the inverse of its last level
  always @(posedge cs_n_i) do_o <= ~do_o;

  always @(posedge sclk_i)
  begin
    if (!cs_n_i)
    begin
      if (cnt < 9)
        cmd = {cmd[7:0], di_i};
      if (cnt == 9)
      begin
        last_cmd = cmd;
        word = 16'hc3a0 + 16'(cmd[5:0]);
        do_o <= 1'b0;
      end
      if (cnt > 9 && cnt < 26)
        do_o <= word[25 - cnt];
      cnt++;
    end
  end
endmodule : rom_model

// ===== testbench.sv
// self-checking bench for the configuration loader
// assumes classic wishbone with one wait state and a serial rom model

`timescale 1ns/10ps

module testbench
  import cfg_loader_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, rom_serial_clock_o, rom_serial_out_o, rom_serial_in_i, rom_select_n_o, rom_select_n_oe_o;
  logic debug_off_strap_i = 1'b1;
  logic protocol_strap_i = 1'b1;
  logic sel_strap = 1'b1;
  logic [2:0] slave_addr_strap_i = 3'h0;
  logic [7:0] gpio_board = 8'h01;
  logic [7:0] gpio_o, gpio_oe_o;
  logic [6:0] slave_addr_o;
  logic i2c_mode_o, debug_mode_o, rom_load_en_o, straps_valid_o;
  logic [1:0] lane_config_o;
  logic [4:0] debug_select_o;
  logic [31:0] q, exp_straps;
  wire logic [7:0] gpio_i;
  wire logic rom_select_n_i;
  int num_errors = 0;
  int samples_checked = 0;

  assign rom_select_n_i = rom_select_n_oe_o ? rom_select_n_o : sel_strap;
  assign gpio_i = (gpio_oe_o & gpio_o) | (~gpio_oe_o & gpio_board);

  always #5 clk_i = ~clk_i;

  cfg_loader uut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .rom_serial_clock_o, .rom_serial_out_o, .rom_serial_in_i, .rom_select_n_i, .rom_select_n_o,
    .rom_select_n_oe_o, .debug_off_strap_i, .protocol_strap_i, .slave_addr_strap_i, .gpio_i, .gpio_o,
    .gpio_oe_o, .slave_addr_o, .i2c_mode_o, .debug_mode_o, .lane_config_o, .debug_select_o, .rom_load_en_o,
    .straps_valid_o);

  rom_model u_rom (.sclk_i(rom_serial_clock_o), .cs_n_i(rom_select_n_i), .di_i(rom_serial_out_o),
    .do_o(rom_serial_in_i));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up

  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= d;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1)
        break;
    end
    q = wb_dat_o;
    if (wb_ack_o !== 1'b1)
    begin
      num_errors++;
      wrap_up();
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb_xfer

  task strap_run(input logic s, input logic dof, input logic pr, input logic [2:0] a, input logic [7:0] g);
    logic [1:0] ln;
    @(posedge clk_i);
    sel_strap <= s;
    debug_off_strap_i <= dof;
    protocol_strap_i <= pr;
    slave_addr_strap_i <= a;
    gpio_board <= g;
    rst_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    ln = (g[1:0] == 2'h3) ? LANE_6P6L : g[1:0];
    exp_straps = {15'h0, s, dof ? 5'h00 : g[4:0], ln, !dof, pr, SLAVE_ADDR_UPPER, a};
    wb_xfer(1'b0, REG_STRAPS, 32'h0);
    check(q, exp_straps);
    check(32'(lane_config_o), 32'(ln));
    $display("test straps done");
  endtask : strap_run

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    strap_run(1'b0, 1'b1, 1'b1, 3'h2, 8'h1f);
    wb_xfer(1'b1, REG_CTRL, 32'h8000_0000);
    wb_xfer(1'b0, REG_STATUS, 32'h0);
    check(q, 32'h30);
    wb_xfer(1'b1, REG_STATUS, 32'h10);
    wb_xfer(1'b0, REG_STATUS, 32'h0);
    check(q, 32'h20);
    strap_run(1'b1, 1'b0, 1'b0, 3'h5, 8'h00);
    strap_run(1'b1, 1'b1, 1'b1, 3'h7, 8'h0d);
    strap_run(1'b1, 1'b0, 1'b1, 3'h5, 8'h16);
    gpio_board <= 8'h03;
    debug_off_strap_i <= 1'b1;
    slave_addr_strap_i <= 3'h0;
    sel_strap <= 1'b0;
    repeat (10) @(posedge clk_i);
    wb_xfer(1'b0, REG_STRAPS, 32'h0);
    check(q, exp_straps);
    wb_xfer(1'b1, REG_GPIO_OE, 32'h0f);
    wb_xfer(1'b1, REG_GPIO_OUT, 32'ha5);
    wb_xfer(1'b0, REG_GPIO_OE, 32'h0);
    check(q, 32'h0f);
    wb_xfer(1'b0, REG_GPIO_OUT, 32'h0);
    check(q, 32'ha5);
    wb_xfer(1'b0, REG_GPIO_IN, 32'h0);
    check(q, 32'h05);
    wb_xfer(1'b0, 8'h40, 32'h0);
    check(q, 32'h0);
    $display("test gpio done");
    wb_xfer(1'b1, REG_CTRL, 32'h8000_022d);
    for (int n = 0; n < 400; n++)
    begin
      wb_xfer(1'b0, REG_STATUS, 32'h0);
      if (q[0] === 1'b0)
        break;
    end
    check(32'(q[0]), 32'h0);
    check(32'(u_rom.last_cmd), 32'h1af);
    wb_xfer(1'b0, REG_CTRL, 32'h0);
    check(q, 32'h2f);
    for (int i = 0; i < 3; i++)
    begin
      wb_xfer(1'b0, REG_DATA, 32'h0);
      check(q, {1'b1, 15'h0, 16'hc3a0 + 16'(6'h2d + i)});
    end
    wb_xfer(1'b0, REG_DATA, 32'h0);
    check(32'(q[31]), 32'h0);
    $display("test rom done");
    wrap_up();
  end
endmodule : testbench
